//--- common/gauge_defines.svh
`ifndef GAUGE_DEFINES_SVH
`define GAUGE_DEFINES_SVH
`define CLK_MHZ 25
`define CLK_HZ 25000000
`define SLEEP_LOW_S 16
`define QUIET_S 1800
`define WAKE_PERIOD_S 14400
`define CHECK_S 900
`define CHECK_EVERY 2'h2
`define BREAK_US 190
`define BREAK_REC_US 40
`define RESP_DELAY_US 190
`define HOST_ZERO_US 70
`define DEV_START_LOW_US 32
`define DEV_ZERO_LOW_US 145
`define DEV_BIT_CYCLE_US 205
`define ADDR_CONTROL 7'h00
`define ADDR_MODE 7'h01
`define ADDR_STATUS 7'h02
`define ADDR_UNLOCK 7'h6e
`define ADDR_NV_FIRST 7'h76
`define ADDR_NV_LAST 7'h7f
`define CMD_SHIP 8'ha9
`define UNLOCK_KEY 8'hdd
`define MODE_SHIP_BIT 0
`define CMD_WRITE_BIT 7
`define NV_BYTES 10
`endif

//--- common/gauge_pkg.sv
package gauge_pkg;
  typedef enum logic [2:0] {
    PM_ACTIVE, PM_SLEEP, PM_WAKE, PM_CHECK, PM_SHIP, PM_HIBERNATE
  } power_t;
  typedef enum logic [2:0] {
    LK_IDLE, LK_LOW, LK_BREAK, LK_RESP, LK_TX_LOW, LK_TX_HIGH
  } link_t;
  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] data;
  } wr_word_t;
  typedef struct packed {
    power_t pm;
    link_t lk;
    logic [39:0] low_cnt;
    logic [39:0] ship_cnt;
    logic [39:0] wake_cnt;
    logic [39:0] quiet_cnt;
    logic [1:0] ticks;
    logic quiet;
    logic [1:0] wake_num;
    logic armed;
    logic por_low;
    logic [15:0] bt;
    logic [2:0] bitn;
    logic [7:0] sh;
    logic data_phase;
    logic [6:0] addr;
    logic push;
    logic drv_oe;
    logic drv;
    logic temp_pulse;
    logic run;
    logic hold_temp;
    logic retain;
    logic unlock;
    logic ship_en;
    logic [9:0][7:0] nv;
  } gauge_state_t;
endpackage

//--- logic/word_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
  parameter int WIDTH = 15,
  parameter int DEPTH = 16
) (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] rd;
    logic [AW-1:0] wr;
    logic [AW:0] cnt;
  } fifo_state_t;
  fifo_state_t s_r, s_nxt;
  logic do_wr, do_rd;

  assign in_ready_o = (s_r.cnt != (AW+1)'(DEPTH));
  assign out_valid_o = (s_r.cnt != '0);
  assign out_data_o = s_r.mem[s_r.rd];
  assign do_wr = in_valid_i && in_ready_o;
  assign do_rd = out_valid_o && out_ready_i;

  always_comb begin
    s_nxt = s_r;
    if (do_wr) begin
      s_nxt.mem[s_r.wr] = in_data_i;
      s_nxt.wr = (s_r.wr == AW'(DEPTH-1)) ? '0 : s_r.wr + 1'b1;
    end
    if (do_rd) begin
      s_nxt.rd = (s_r.rd == AW'(DEPTH-1)) ? '0 : s_r.rd + 1'b1;
    end
    s_nxt.cnt = s_r.cnt + (AW+1)'(do_wr) - (AW+1)'(do_rd);
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  a_fifo_no_overflow: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    s_r.cnt <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule // word_fifo
`default_nettype wire

//--- logic/gauge_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "gauge_defines.svh"
module gauge_port #(
  parameter longint unsigned SLEEP_LOW_CYC = longint'(`SLEEP_LOW_S) * `CLK_HZ,
  parameter longint unsigned QUIET_CYC = longint'(`QUIET_S) * `CLK_HZ,
  parameter longint unsigned WAKE_CYC = longint'(`WAKE_PERIOD_S) * `CLK_HZ,
  parameter longint unsigned CHECK_CYC = longint'(`CHECK_S) * `CLK_HZ,
  parameter int LINK_CLK_MHZ = `CLK_MHZ,
  parameter longint unsigned BREAK_CYC = `BREAK_US * LINK_CLK_MHZ,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic single_wire_host_line_i,
  output logic single_wire_host_line_o,
  output logic single_wire_host_line_oe_o,
  input wire logic activity_i,
  input wire logic filter_zero_i,
  input wire logic charge_counter_converter_tick_i,
  input wire logic supply_ok_i,
  input wire logic backup_supply_pin_i,
  output gauge_pkg::power_t power_mode_o,
  output logic temp_convert_o,
  output logic gauge_run_o,
  output logic hold_temp_o,
  output logic retain_o
);
  // -----------------------------------------------------------------
  // link timing
  // -----------------------------------------------------------------
  localparam logic [15:0] BREAK_REC_CYC = 16'(`BREAK_REC_US * LINK_CLK_MHZ);
  localparam logic [15:0] RESP_CYC = 16'(`RESP_DELAY_US * LINK_CLK_MHZ);
  localparam logic [15:0] HOST_ZERO_CYC = 16'(`HOST_ZERO_US * LINK_CLK_MHZ);
  localparam logic [15:0] DEV_ONE_CYC = 16'(`DEV_START_LOW_US * LINK_CLK_MHZ);
  localparam logic [15:0] DEV_ZERO_CYC = 16'(`DEV_ZERO_LOW_US * LINK_CLK_MHZ);
  localparam logic [15:0] DEV_CYC = 16'(`DEV_BIT_CYCLE_US * LINK_CLK_MHZ);
  localparam logic [39:0] SLEEP_LOW = 40'(SLEEP_LOW_CYC);
  localparam logic [39:0] QUIET = 40'(QUIET_CYC);
  localparam logic [39:0] WAKE = 40'(WAKE_CYC);
  localparam logic [39:0] CHECK = 40'(CHECK_CYC);
  localparam logic [15:0] BRK = 16'(BREAK_CYC);

  gauge_pkg::gauge_state_t s_r, s_nxt;
  gauge_pkg::wr_word_t rx_word, wr_word;
  logic line;
  logic fifo_in_ready, fifo_out_valid, drain_ready, fifo_empty;
  logic low_bit;
  logic [7:0] rd_data;
  logic [3:0] nv_idx;

  assign line = single_wire_host_line_i;
  assign rx_word = '{addr: s_r.addr, data: s_r.sh};
  // drain stalls while bits are going out on the line
  assign drain_ready = (s_r.lk != gauge_pkg::LK_TX_LOW) && (s_r.lk != gauge_pkg::LK_TX_HIGH);
  assign fifo_empty = !fifo_out_valid;
  assign low_bit = (s_r.bt < HOST_ZERO_CYC);
  assign nv_idx = 4'(s_r.addr - `ADDR_NV_FIRST);

  word_fifo #(
    .WIDTH($bits(gauge_pkg::wr_word_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_wr_fifo (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .in_valid_i(s_r.push),
    .in_ready_o(fifo_in_ready),
    .in_data_i(rx_word),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(drain_ready),
    .out_data_o(wr_word)
  );

  // -----------------------------------------------------------------
  // register read mux
  // -----------------------------------------------------------------
  always_comb begin
    rd_data = 8'h00;
    if (s_r.addr == `ADDR_MODE) begin
      rd_data = {7'h00, s_r.ship_en};
    end else if (s_r.addr == `ADDR_STATUS) begin
      rd_data = {s_r.armed, s_r.unlock, s_r.quiet, 2'h0, s_r.pm};
    end else if (s_r.addr >= `ADDR_NV_FIRST) begin
      rd_data = s_r.nv[nv_idx];
    end
  end

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.temp_pulse = 1'b0;
    s_nxt.drv = 1'b0;

    // register writes leave the fifo here
    if (fifo_out_valid && drain_ready) begin
      unique case (wr_word.addr)
        `ADDR_CONTROL: begin
          if (wr_word.data == `CMD_SHIP && s_r.ship_en) begin
            s_nxt.armed = 1'b1;
            s_nxt.ship_cnt = '0;
          end
        end
        `ADDR_MODE: s_nxt.ship_en = wr_word.data[`MODE_SHIP_BIT];
        `ADDR_UNLOCK: s_nxt.unlock = (wr_word.data == `UNLOCK_KEY);
        default: begin
          if (wr_word.addr >= `ADDR_NV_FIRST && s_r.unlock) begin
            s_nxt.nv[4'(wr_word.addr - `ADDR_NV_FIRST)] = wr_word.data;
          end
        end
      endcase
    end
    if (s_r.push && fifo_in_ready) begin
      s_nxt.push = 1'b0;
    end

    // link receiver and transmitter
    unique case (s_r.lk)
      gauge_pkg::LK_IDLE: begin
        if (!line && !s_r.push) begin
          s_nxt.lk = gauge_pkg::LK_LOW;
          s_nxt.bt = '0;
        end
      end
      gauge_pkg::LK_LOW: begin
        s_nxt.bt = s_r.bt + 16'h0001;
        if (s_r.bt >= BRK) begin
          s_nxt.lk = gauge_pkg::LK_BREAK;
          s_nxt.bitn = '0;
          s_nxt.data_phase = 1'b0;
          s_nxt.bt = '0;
        end else if (line) begin
          // short low is a one, long low a zero; lsb arrives first
          s_nxt.sh = {low_bit, s_r.sh[7:1]};
          s_nxt.bitn = s_r.bitn + 3'h1;
          s_nxt.lk = gauge_pkg::LK_IDLE;
          if (s_r.bitn == 3'h7) begin
            if (s_r.data_phase) begin
              s_nxt.push = 1'b1;
              s_nxt.data_phase = 1'b0;
            end else begin
              s_nxt.addr = s_r.sh[7:1];
              if (low_bit) begin
                s_nxt.data_phase = 1'b1;
              end else begin
                s_nxt.lk = gauge_pkg::LK_RESP;
                s_nxt.bt = '0;
              end
            end
          end
        end
      end
      gauge_pkg::LK_BREAK: begin
        s_nxt.bt = line ? s_r.bt + 16'h0001 : '0;
        if (line && s_r.bt >= BREAK_REC_CYC) begin
          s_nxt.lk = gauge_pkg::LK_IDLE;
        end
      end
      gauge_pkg::LK_RESP: begin
        // pending writes land first so a read sees them
        if (fifo_empty) begin
          s_nxt.bt = s_r.bt + 16'h0001;
        end
        if (fifo_empty && s_r.bt >= RESP_CYC) begin
          s_nxt.sh = rd_data;
          s_nxt.bitn = '0;
          s_nxt.bt = '0;
          s_nxt.drv_oe = 1'b1;
          s_nxt.lk = gauge_pkg::LK_TX_LOW;
        end
      end
      gauge_pkg::LK_TX_LOW: begin
        s_nxt.bt = s_r.bt + 16'h0001;
        if (s_r.bt >= (s_r.sh[0] ? DEV_ONE_CYC : DEV_ZERO_CYC) - 16'h0001) begin
          s_nxt.drv_oe = 1'b0;
          s_nxt.lk = gauge_pkg::LK_TX_HIGH;
        end
      end
      gauge_pkg::LK_TX_HIGH: begin
        s_nxt.bt = s_r.bt + 16'h0001;
        if (s_r.bt >= DEV_CYC - 16'h0001) begin
          s_nxt.sh = {1'b0, s_r.sh[7:1]};
          s_nxt.bitn = s_r.bitn + 3'h1;
          s_nxt.bt = '0;
          if (s_r.bitn == 3'h7) begin
            s_nxt.lk = gauge_pkg::LK_IDLE;
          end else begin
            s_nxt.drv_oe = 1'b1;
            s_nxt.lk = gauge_pkg::LK_TX_LOW;
          end
        end
      end
      default: s_nxt.lk = gauge_pkg::LK_IDLE;
    endcase

    // activity qualification
    if (filter_zero_i) begin
      s_nxt.quiet_cnt = s_r.quiet_cnt + 40'h1;
      if (charge_counter_converter_tick_i && s_r.ticks != 2'h2) begin
        s_nxt.ticks = s_r.ticks + 2'h1;
      end
      if (s_r.quiet_cnt >= CHECK - 40'h1) begin
        s_nxt.quiet = (s_r.ticks < 2'h2);
        s_nxt.quiet_cnt = '0;
        s_nxt.ticks = '0;
      end
    end else if (activity_i) begin
      s_nxt.quiet = 1'b0;
      s_nxt.quiet_cnt = '0;
    end else if (s_r.quiet_cnt >= QUIET - 40'h1) begin
      s_nxt.quiet = 1'b1;
    end else begin
      s_nxt.quiet_cnt = s_r.quiet_cnt + 40'h1;
    end

    // low time of the line
    s_nxt.low_cnt = line ? '0 : s_r.low_cnt + 40'h1;
    if (s_r.armed && !line) begin
      s_nxt.ship_cnt = s_r.ship_cnt + 40'h1;
    end

    // power modes
    unique case (s_r.pm)
      gauge_pkg::PM_ACTIVE: begin
        if (s_r.armed && s_r.ship_cnt >= SLEEP_LOW) begin
          s_nxt.pm = gauge_pkg::PM_SHIP;
          s_nxt.por_low = 1'b0;
        end else if (!s_r.armed && s_r.low_cnt >= SLEEP_LOW && s_r.quiet) begin
          s_nxt.pm = gauge_pkg::PM_SLEEP;
          s_nxt.wake_cnt = '0;
          s_nxt.wake_num = '0;
        end
      end
      gauge_pkg::PM_SLEEP: begin
        s_nxt.wake_cnt = s_r.wake_cnt + 40'h1;
        if (line) begin
          s_nxt.pm = gauge_pkg::PM_ACTIVE;
        end else if (s_r.armed && s_r.ship_cnt >= SLEEP_LOW) begin
          s_nxt.pm = gauge_pkg::PM_SHIP;
          s_nxt.por_low = 1'b0;
        end else if (s_r.wake_cnt >= WAKE - 40'h1) begin
          s_nxt.temp_pulse = 1'b1;
          s_nxt.wake_cnt = '0;
          s_nxt.wake_num = (s_r.wake_num == `CHECK_EVERY) ? 2'h0 : s_r.wake_num + 2'h1;
          s_nxt.pm = (s_r.wake_num == 2'h0) ? gauge_pkg::PM_CHECK : gauge_pkg::PM_WAKE;
        end
      end
      gauge_pkg::PM_WAKE: begin
        s_nxt.wake_cnt = s_r.wake_cnt + 40'h1;
        if (line) begin
          s_nxt.pm = gauge_pkg::PM_ACTIVE;
        end else if (s_r.wake_cnt >= SLEEP_LOW - 40'h1) begin
          s_nxt.pm = gauge_pkg::PM_SLEEP;
          s_nxt.wake_cnt = '0;
        end
      end
      gauge_pkg::PM_CHECK: begin
        s_nxt.wake_cnt = s_r.wake_cnt + 40'h1;
        if (line || activity_i) begin
          s_nxt.pm = gauge_pkg::PM_ACTIVE;
        end else if (s_r.wake_cnt >= CHECK - 40'h1) begin
          s_nxt.pm = gauge_pkg::PM_SLEEP;
          s_nxt.wake_cnt = '0;
        end
      end
      gauge_pkg::PM_SHIP: begin
        if (!supply_ok_i) begin
          s_nxt.por_low = 1'b1;
        end
        if ((line && supply_ok_i) || (s_r.por_low && supply_ok_i)) begin
          s_nxt.pm = gauge_pkg::PM_ACTIVE;
          s_nxt.armed = 1'b0;
        end
      end
      gauge_pkg::PM_HIBERNATE: begin
        if (supply_ok_i) begin
          s_nxt.pm = gauge_pkg::PM_ACTIVE;
        end
      end
      default: s_nxt.pm = gauge_pkg::PM_ACTIVE;
    endcase
    if (!supply_ok_i && backup_supply_pin_i) begin
      s_nxt.pm = gauge_pkg::PM_HIBERNATE;
    end

    s_nxt.run = (s_nxt.pm == gauge_pkg::PM_ACTIVE) || (s_nxt.pm == gauge_pkg::PM_CHECK);
    s_nxt.hold_temp = (s_nxt.pm == gauge_pkg::PM_SLEEP);
    s_nxt.retain = (s_nxt.pm == gauge_pkg::PM_HIBERNATE);
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      s_r <= '0;
      s_r.pm <= gauge_pkg::PM_ACTIVE;
      s_r.lk <= gauge_pkg::LK_IDLE;
      s_r.run <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign single_wire_host_line_o = s_r.drv;
  assign single_wire_host_line_oe_o = s_r.drv_oe;
  assign power_mode_o = s_r.pm;
  assign temp_convert_o = s_r.temp_pulse;
  assign gauge_run_o = s_r.run;
  assign hold_temp_o = s_r.hold_temp;
  assign retain_o = s_r.retain;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);

  a_sleep_low_time: assert property (
    s_r.pm == gauge_pkg::PM_ACTIVE ##1 s_r.pm == gauge_pkg::PM_SLEEP
    |-> $past(s_r.low_cnt) >= SLEEP_LOW && $past(s_r.quiet)) else $error("sleep too early");
  a_wake_temp_pulse: assert property (
    s_r.pm == gauge_pkg::PM_SLEEP ##1 s_r.pm inside {gauge_pkg::PM_WAKE, gauge_pkg::PM_CHECK}
    |-> s_r.temp_pulse) else $error("wake without temperature pulse");
  a_sleep_hold_temp: assert property (
    s_r.pm == gauge_pkg::PM_SLEEP |-> s_r.hold_temp && !s_r.run) else $error("sleep not holding");
  a_high_ends_sleep: assert property (
    s_r.pm == gauge_pkg::PM_SLEEP && line && supply_ok_i
    |=> s_r.pm == gauge_pkg::PM_ACTIVE) else $error("high line kept sleep");
  a_ship_needs_arm: assert property (
    s_r.pm != gauge_pkg::PM_SHIP ##1 s_r.pm == gauge_pkg::PM_SHIP
    |-> $past(s_r.armed) && $past(s_r.ship_cnt) >= SLEEP_LOW) else $error("ship unarmed");
  a_ship_exit_disarm: assert property (
    s_r.pm == gauge_pkg::PM_SHIP && line && supply_ok_i
    |=> s_r.pm == gauge_pkg::PM_ACTIVE && !s_r.armed) else $error("ship exit kept arm");
  a_hibernate_entry: assert property (
    !supply_ok_i && backup_supply_pin_i
    |=> s_r.pm == gauge_pkg::PM_HIBERNATE && s_r.retain) else $error("no hibernate");
  a_nv_locked: assert property (
    s_r.nv != $past(s_r.nv) |-> $past(s_r.unlock)) else $error("nv write while locked");
  a_break_abort: assert property (
    s_r.lk == gauge_pkg::LK_LOW && s_r.bt >= BRK
    |=> s_r.lk == gauge_pkg::LK_BREAK && s_r.bitn == 3'h0 && !s_r.drv_oe) else $error("break lost");
endmodule // gauge_port
`default_nettype wire

//--- verification/host_line_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------
// host end of the open-drain line, pull-up when released
// ------
module host_line_model #(
  parameter int CELL_CYC = 5000,
  parameter int ONE_LOW_CYC = 250,
  parameter int ZERO_LOW_CYC = 2500,
  parameter int BREAK_LOW_CYC = 9500,
  parameter int BREAK_REC_CYC = 1500,
  parameter int SPLIT_CYC = 2000
) (
  input wire logic sys_clk_i,
  input wire logic dev_oe_i,
  output logic host_rel_o
);
  initial host_rel_o = 1'b1;

  task automatic hold_low(input int n);
    host_rel_o <= 1'b0;
    repeat (n) @(posedge sys_clk_i);
    host_rel_o <= 1'b1;
  endtask

  // twice the minimum break, then recovery high
  task automatic send_break();
    hold_low(BREAK_LOW_CYC);
    repeat (BREAK_REC_CYC) @(posedge sys_clk_i);
  endtask

  task automatic send_bits(input logic [7:0] b, input int cnt);
    int low;
    for (int i = 0; i < cnt; i++) begin
      low = b[i] ? ONE_LOW_CYC : ZERO_LOW_CYC;
      hold_low(low);
      repeat (CELL_CYC - low) @(posedge sys_clk_i);
    end
  endtask

  task automatic recv_byte(output logic [7:0] b, output logic ok);
    int n;
    ok = 1'b1;
    b = 8'h00;
    for (int i = 0; i < 8; i++) begin
      n = 0;
      while (dev_oe_i !== 1'b1 && n < 12000) begin
        @(posedge sys_clk_i);
        n++;
      end
      ok = ok & (n < 12000);
      n = 0;
      while (dev_oe_i === 1'b1 && n < 5000) begin
        @(posedge sys_clk_i);
        n++;
      end
      b[i] = (n < SPLIT_CYC);
    end
    // let the last device bit cell run out before the host talks again
    repeat (CELL_CYC) @(posedge sys_clk_i);
  endtask
endmodule // host_line_model
`default_nettype wire

//--- verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic sys_clk_i;
  logic rstn_i;
  logic host_rel;
  logic line_w;
  logic dev_line;
  logic dev_oe;
  logic activity;
  logic filter_zero;
  logic tick;
  logic supply_ok;
  logic backup;
  gauge_pkg::power_t pm;
  logic temp_pulse;
  logic run;
  logic hold_temp;
  logic retain;
  gauge_pkg::power_t modes[$];
  int fail_count;
  int checks;
  int tick_gap;
  int tick_cnt = 0;
  int temp_seen = 0;

  assign line_w = host_rel & ~(dev_oe & ~dev_line);

  // link time base lowered so that bit cells stay short in cycles
  gauge_port #(.SLEEP_LOW_CYC(200), .QUIET_CYC(300), .WAKE_CYC(500), .CHECK_CYC(150),
    .LINK_CLK_MHZ(5)) u_dut (
    .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .single_wire_host_line_i(line_w),
    .single_wire_host_line_o(dev_line), .single_wire_host_line_oe_o(dev_oe),
    .activity_i(activity), .filter_zero_i(filter_zero),
    .charge_counter_converter_tick_i(tick), .supply_ok_i(supply_ok),
    .backup_supply_pin_i(backup), .power_mode_o(pm), .temp_convert_o(temp_pulse),
    .gauge_run_o(run), .hold_temp_o(hold_temp), .retain_o(retain));

  host_line_model #(.CELL_CYC(1000), .ONE_LOW_CYC(50), .ZERO_LOW_CYC(500),
    .BREAK_LOW_CYC(1900), .BREAK_REC_CYC(300), .SPLIT_CYC(400)) u_host (
    .sys_clk_i(sys_clk_i), .dev_oe_i(dev_oe), .host_rel_o(host_rel));

  initial begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end

  always @(posedge sys_clk_i) begin
    tick_cnt <= (tick_cnt >= tick_gap - 1) ? 0 : tick_cnt + 1;
    tick <= (tick_gap != 0) && (tick_cnt == 0);
    if (temp_pulse === 1'b1) temp_seen <= temp_seen + 1;
  end

  // ------
  // helpers
  // ------
  task automatic check(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("MISMATCH t=%0t %s", $time, msg);
    end
  endtask

  task automatic set_env(input logic act, input logic fz, input logic sup, input logic bk);
    activity <= act;
    filter_zero <= fz;
    supply_ok <= sup;
    backup <= bk;
  endtask

  task automatic wait_mode(input gauge_pkg::power_t m, input int n, input string msg);
    int k;
    k = 0;
    @(negedge sys_clk_i);
    while (pm !== m && k < n) begin
      @(negedge sys_clk_i);
      k++;
    end
    check(pm === m, msg);
    @(posedge sys_clk_i);
  endtask

  task automatic record(input int n);
    gauge_pkg::power_t last;
    last = pm;
    modes = {};
    repeat (n) begin
      @(negedge sys_clk_i);
      if (pm !== last) begin
        modes.push_back(pm);
        check(hold_temp === (pm === gauge_pkg::PM_SLEEP), "hold temp");
        check(run === (pm inside {gauge_pkg::PM_ACTIVE, gauge_pkg::PM_CHECK}), "run");
      end
      last = pm;
    end
  endtask

  task automatic close_out();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ------
  // scenarios
  // ------
  task automatic s_no_sleep_busy();
    set_env(1'b1, 1'b0, 1'b1, 1'b0);
    u_host.hold_low(300);
    check(pm === gauge_pkg::PM_ACTIVE, "slept while busy");
  endtask

  task automatic s_sleep_cycle();
    gauge_pkg::power_t exp_seq[8];
    int t0;
    exp_seq = '{gauge_pkg::PM_SLEEP, gauge_pkg::PM_CHECK, gauge_pkg::PM_SLEEP,
      gauge_pkg::PM_WAKE, gauge_pkg::PM_SLEEP, gauge_pkg::PM_WAKE,
      gauge_pkg::PM_SLEEP, gauge_pkg::PM_CHECK};
    set_env(1'b0, 1'b0, 1'b1, 1'b0);
    repeat (350) @(posedge sys_clk_i);
    t0 = temp_seen;
    fork
      u_host.hold_low(5200);
      record(5200);
    join
    for (int i = 0; i < 8; i++) begin
      check(modes.size() > i && modes[i] === exp_seq[i], "mode order");
    end
    check(temp_seen - t0 >= 4, "temp conversions");
    wait_mode(gauge_pkg::PM_ACTIVE, 4, "line high exit");
    fork
      u_host.hold_low(260);
      begin
        repeat (150) @(posedge sys_clk_i);
        check(pm === gauge_pkg::PM_ACTIVE, "early resleep");
        wait_mode(gauge_pkg::PM_SLEEP, 100, "resleep");
      end
    join
  endtask

  task automatic s_zero_filter();
    set_env(1'b0, 1'b1, 1'b1, 1'b0);
    tick_gap <= 60;
    repeat (400) @(posedge sys_clk_i);
    u_host.hold_low(300);
    check(pm === gauge_pkg::PM_ACTIVE, "slept with counts");
    tick_gap <= 400;
    repeat (400) @(posedge sys_clk_i);
    fork
      u_host.hold_low(300);
      wait_mode(gauge_pkg::PM_SLEEP, 290, "zero filter sleep");
    join
    set_env(1'b0, 1'b0, 1'b1, 1'b0);
    tick_gap <= 0;
  endtask

  task automatic s_hibernate();
    set_env(1'b0, 1'b0, 1'b0, 1'b1);
    wait_mode(gauge_pkg::PM_HIBERNATE, 5, "hibernate entry");
    check(retain === 1'b1, "retain");
    set_env(1'b0, 1'b0, 1'b1, 1'b1);
    wait_mode(gauge_pkg::PM_ACTIVE, 5, "hibernate exit");
    check(retain === 1'b0, "retain off");
    set_env(1'b0, 1'b0, 1'b1, 1'b0);
  endtask

  task automatic s_nv_program();
    logic [7:0] b;
    logic ok;
    set_env(1'b1, 1'b0, 1'b1, 1'b0);
    u_host.send_bits(8'h00, 3);
    u_host.send_break();
    u_host.send_bits(8'hee, 8);
    u_host.send_bits(8'hdd, 8);
    u_host.send_bits(8'hf6, 8);
    u_host.send_bits(8'h5a, 8);
    u_host.send_bits(8'h76, 8);
    u_host.recv_byte(b, ok);
    check(ok === 1'b1 && b === 8'h5a, "nv read back");
    check(dev_line === 1'b0, "device drives line low only");
  endtask

  task automatic s_ship();
    u_host.send_bits(8'h81, 8);
    u_host.send_bits(8'h01, 8);
    u_host.send_bits(8'h80, 8);
    u_host.send_bits(8'ha9, 8);
    u_host.hold_low(120);
    repeat (30) @(posedge sys_clk_i);
    check(pm === gauge_pkg::PM_ACTIVE, "early ship");
    fork
      u_host.hold_low(150);
      begin
        wait_mode(gauge_pkg::PM_SHIP, 140, "ship entry");
        check(run === 1'b0, "ship halts");
      end
    join
    wait_mode(gauge_pkg::PM_ACTIVE, 5, "ship exit");
    set_env(1'b0, 1'b0, 1'b1, 1'b0);
    repeat (350) @(posedge sys_clk_i);
    fork
      u_host.hold_low(400);
      wait_mode(gauge_pkg::PM_SLEEP, 300, "sleep not ship");
    join
  endtask

  // ------
  // main sequence and watchdog
  // ------
  initial begin
    rstn_i = 1'b0;
    set_env(1'b1, 1'b0, 1'b1, 1'b0);
    tick_gap = 0;
    fail_count = 0;
    checks = 0;
    repeat (20) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    @(negedge sys_clk_i);
    check(pm === gauge_pkg::PM_ACTIVE && run === 1'b1 && dev_oe === 1'b0, "reset");
    check(hold_temp === 1'b0 && retain === 1'b0 && temp_pulse === 1'b0, "reset outs");
    @(posedge sys_clk_i);
    s_no_sleep_busy();
    s_sleep_cycle();
    s_zero_filter();
    s_hibernate();
    s_nv_program();
    s_ship();
    close_out();
  end

  initial begin
    repeat (110000) @(posedge sys_clk_i);
    fail_count++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    close_out();
  end
endmodule // tb
`default_nettype wire
